// ---- inc/ccr_pkg.sv ----
package ccr_pkg;

  // register bus geometry: byte addresses, one aligned 32-bit word per register
  localparam int unsigned CCR_ADDR_W = 8;
  localparam int unsigned CCR_DATA_W = 32;
  localparam int unsigned CCR_REG_W = 16;
  localparam int unsigned CCR_NREGS = 6;

  // printed register indices; byte address is four times the index
  localparam logic [5:0] CCR_IDX_CHAN1_GAIN_LOWER = 6'h12;
  localparam logic [5:0] CCR_IDX_CHAN2_CONFIG = 6'h13;
  localparam logic [5:0] CCR_IDX_CHAN2_OFFSET_UPPER = 6'h14;
  localparam logic [5:0] CCR_IDX_CHAN2_OFFSET_LOWER = 6'h15;
  localparam logic [5:0] CCR_IDX_CHAN2_GAIN_UPPER = 6'h16;
  localparam logic [5:0] CCR_IDX_CHAN2_GAIN_LOWER = 6'h17;
  localparam logic [5:0] CCR_IDX_FIRST = CCR_IDX_CHAN1_GAIN_LOWER;
  localparam logic [5:0] CCR_IDX_LAST = CCR_IDX_CHAN2_GAIN_LOWER;

  // slot numbers inside the bank, slot = index - first index
  localparam int unsigned CCR_SLOT_C1_GLO = 0;
  localparam int unsigned CCR_SLOT_C2_CFG = 1;
  localparam int unsigned CCR_SLOT_C2_OHI = 2;
  localparam int unsigned CCR_SLOT_C2_OLO = 3;
  localparam int unsigned CCR_SLOT_C2_GHI = 4;
  localparam int unsigned CCR_SLOT_C2_GLO = 5;

  // reset values per slot, slot 5 first
  localparam logic [CCR_NREGS-1:0][15:0] CCR_RESET = {
    16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000
  };

  // writable bits per slot; zero bits are reserved and read as zero
  localparam logic [CCR_NREGS-1:0][15:0] CCR_WMASK = {
    16'hff00, 16'hffff, 16'hff00, 16'hffff, 16'hffc7, 16'hff00
  };

  // configuration word fields
  localparam int unsigned CCR_CFG_DELAY_MSB = 15;
  localparam int unsigned CCR_CFG_DELAY_LSB = 6;
  localparam int unsigned CCR_CFG_DC_OFF_BIT = 2;
  localparam int unsigned CCR_CFG_SEL_MSB = 1;
  localparam int unsigned CCR_CFG_SEL_LSB = 0;
  // lower registers keep their byte in bits 15:8
  localparam int unsigned CCR_LO_MSB = 15;
  localparam int unsigned CCR_LO_LSB = 8;

  // input selector codes
  localparam logic [1:0] CCR_SEL_OWN_PAIR = 2'h0;
  localparam logic [1:0] CCR_SEL_SHORTED = 2'h1;
  localparam logic [1:0] CCR_SEL_POS_TEST = 2'h2;
  localparam logic [1:0] CCR_SEL_NEG_TEST = 2'h3;

  // avalon response codes
  localparam logic [1:0] CCR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CCR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CCR_BUS_IDLE = 2'b00,
    CCR_BUS_ACK = 2'b01
  } ccr_bus_st_e;

  // calibration values handed to the channel datapath
  typedef struct packed {
    logic [9:0] chan2_delay_field;
    logic chan2_dc_removal_off;
    logic chan2_dc_removal_en;
    logic [1:0] chan2_input_select;
    logic [3:0] chan2_input_onehot;
    logic [23:0] chan2_offset;
    logic [23:0] chan2_gain;
    logic [7:0] chan1_gain_low;
  } ccr_cal_s;

endpackage

// ---- verilog/ccr_field_unit.sv ----
`timescale 1ns/1ps

// one 16-bit register with byte-lane writes and hard-wired reserved bits
module ccr_field_unit
  import ccr_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hffff
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [1:0] byteen_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] value_o
);

  typedef struct packed {
    logic [15:0] val;
  } ccr_fu_state_s;

  ccr_fu_state_s s_q;
  ccr_fu_state_s s_d;
  logic [15:0] lane_mask;

  assign lane_mask = {{8{byteen_i[1]}}, {8{byteen_i[0]}}};

  always_comb begin
    s_d = s_q;
    if (wr_en_i) begin
      s_d.val = ((s_q.val & ~lane_mask) | (wdata_i & lane_mask)) & WR_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      s_q.val <= RESET_VAL & WR_MASK;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign value_o = s_q.val;

endmodule // ccr_field_unit

// ---- verilog/ccr_regs.sv ----
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module ccr_regs
  import ccr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [CCR_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [CCR_DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [CCR_DATA_W-1:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // global dc removal enable for channel 2, from same-clock logic
  input wire logic global_dc_removal_setting_i,
  output ccr_cal_s cal_o
);

  typedef struct packed {
    ccr_bus_st_e st;
    logic [CCR_DATA_W-1:0] rdata;
    logic [1:0] resp;
    logic hit;
    logic [2:0] slot;
    ccr_cal_s cal;
  } ccr_state_s;

  ccr_state_s s_q;
  ccr_state_s s_d;

  logic [CCR_NREGS-1:0][15:0] reg_val;
  logic [CCR_NREGS-1:0] reg_wr;
  logic [5:0] req_idx;
  logic req_hit;
  logic [2:0] req_slot;
  logic req_any;
  logic commit_wr;

  // word index of a byte address; the low two bits select no lane here
  function automatic logic [5:0] word_index(input logic [CCR_ADDR_W-1:0] addr);
    word_index = addr[7:2];
  endfunction

  function automatic logic in_bank(input logic [5:0] idx);
    in_bank = (idx >= CCR_IDX_FIRST) && (idx <= CCR_IDX_LAST);
  endfunction

  function automatic logic [2:0] slot_of(input logic [5:0] idx);
    logic [5:0] diff;
    diff = idx - CCR_IDX_FIRST;
    slot_of = diff[2:0];
  endfunction

  // one-hot view of the input selector for the front-end switches
  function automatic logic [3:0] sel_onehot(input logic [1:0] sel);
    logic [3:0] oh;
    oh = 4'h0;
    case (sel)
      CCR_SEL_OWN_PAIR: oh = 4'h1;
      CCR_SEL_SHORTED: oh = 4'h2;
      CCR_SEL_POS_TEST: oh = 4'h4;
      CCR_SEL_NEG_TEST: oh = 4'h8;
      default: oh = 4'h0;
    endcase
    sel_onehot = oh;
  endfunction

  assign req_idx = word_index(avs_address_i);
  assign req_hit = in_bank(req_idx);
  assign req_slot = slot_of(req_idx);
  assign req_any = avs_read_i || avs_write_i;

  // a write lands only on the edge where waitrequest is seen low
  assign commit_wr = ce_i && (s_q.st == CCR_BUS_ACK) && avs_write_i && s_q.hit;

  // offsets and lower gain reset to zero
  genvar g;
  generate
    for (g = 0; g < CCR_NREGS; g++) begin : g_reg
      assign reg_wr[g] = commit_wr && (s_q.slot == 3'(g));
      ccr_field_unit #(
        .RESET_VAL(CCR_RESET[g]),
        .WR_MASK(CCR_WMASK[g])
      ) u_field (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .wr_en_i(reg_wr[g]),
        .byteen_i(avs_byteenable_i[1:0]),
        .wdata_i(avs_writedata_i[15:0]),
        .value_o(reg_val[g])
      );
    end
  endgenerate

  always_comb begin
    logic [15:0] cfg;
    logic [15:0] rd16;
    cfg = reg_val[CCR_SLOT_C2_CFG];
    rd16 = 16'h0000;
    s_d = s_q;

    case (s_q.st)
      CCR_BUS_IDLE: begin
        if (req_any) begin
          s_d.st = CCR_BUS_ACK;
          s_d.hit = req_hit;
          s_d.slot = req_slot;
          if (req_hit) begin
            rd16 = reg_val[req_slot];
          end
          s_d.rdata = {16'h0000, rd16};
          s_d.resp = req_hit ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
        end
      end
      CCR_BUS_ACK: begin
        s_d.st = CCR_BUS_IDLE;
      end
      default: begin
        s_d.st = CCR_BUS_IDLE;
      end
    endcase

    s_d.cal.chan2_delay_field = cfg[CCR_CFG_DELAY_MSB:CCR_CFG_DELAY_LSB];
    s_d.cal.chan2_dc_removal_off = cfg[CCR_CFG_DC_OFF_BIT];
    s_d.cal.chan2_dc_removal_en = global_dc_removal_setting_i && !cfg[CCR_CFG_DC_OFF_BIT];
    s_d.cal.chan2_input_select = cfg[CCR_CFG_SEL_MSB:CCR_CFG_SEL_LSB];
    s_d.cal.chan2_input_onehot = sel_onehot(cfg[CCR_CFG_SEL_MSB:CCR_CFG_SEL_LSB]);
    // offset low byte from bits 15:8
    s_d.cal.chan2_offset = {reg_val[CCR_SLOT_C2_OHI], reg_val[CCR_SLOT_C2_OLO][CCR_LO_MSB:CCR_LO_LSB]};
    // gain low byte from bits 15:8
    s_d.cal.chan2_gain = {reg_val[CCR_SLOT_C2_GHI], reg_val[CCR_SLOT_C2_GLO][CCR_LO_MSB:CCR_LO_LSB]};
    s_d.cal.chan1_gain_low = reg_val[CCR_SLOT_C1_GLO][CCR_LO_MSB:CCR_LO_LSB];
  end

  // the cal copy lags the registers by one cycle; it is reset to match them
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      s_q.st <= CCR_BUS_IDLE;
      s_q.rdata <= 32'h0000_0000;
      s_q.resp <= CCR_RESP_OKAY;
      s_q.hit <= 1'b0;
      s_q.slot <= 3'h0;
      s_q.cal.chan2_delay_field <= 10'h000;
      s_q.cal.chan2_dc_removal_off <= 1'b0;
      s_q.cal.chan2_dc_removal_en <= 1'b0;
      s_q.cal.chan2_input_select <= CCR_SEL_OWN_PAIR;
      s_q.cal.chan2_input_onehot <= 4'h1;
      s_q.cal.chan2_offset <= {CCR_RESET[CCR_SLOT_C2_OHI], CCR_RESET[CCR_SLOT_C2_OLO][CCR_LO_MSB:CCR_LO_LSB]};
      s_q.cal.chan2_gain <= {CCR_RESET[CCR_SLOT_C2_GHI], CCR_RESET[CCR_SLOT_C2_GLO][CCR_LO_MSB:CCR_LO_LSB]};
      s_q.cal.chan1_gain_low <= CCR_RESET[CCR_SLOT_C1_GLO][CCR_LO_MSB:CCR_LO_LSB];
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest_o = (s_q.st != CCR_BUS_ACK);
  assign avs_readdata_o = s_q.rdata;
  assign avs_response_o = s_q.resp;
  assign cal_o = s_q.cal;

endmodule // ccr_regs

// ---- bench/ccr_regs_assertions.sv ----
`timescale 1ns/1ps
module ccr_regs_chk
  import ccr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic global_dc_removal_setting_i,
  input wire ccr_cal_s cal_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [5:0] ix = avs_address_i[7:2];
  wire logic rd_ack = avs_read_i && !avs_waitrequest_o;
  // full-word write taken, acked, then one more enabled edge before cal_o shows it
  sequence s_wr(idx);
    avs_write_i && avs_waitrequest_o && ce_i && ix == idx && avs_byteenable_i[1:0] == 2'h3
      ##1 !avs_waitrequest_o && ce_i ##1 ce_i;
  endsequence
  property p_upd(idx, got, m);
    s_wr(idx) |=> got == ($past(avs_writedata_i[15:0], 3) & m);
  endproperty
  AST_CFG_WR:
    assert property (p_upd(6'h13, {cal_o.chan2_delay_field, 3'h0, cal_o.chan2_dc_removal_off,
      cal_o.chan2_input_select}, 16'hffc7)) else $error("cfg write lost");
  AST_OFS_HI:
    assert property (p_upd(6'h14, cal_o.chan2_offset[23:8], 16'hffff)) else $error("offset high lost");
  AST_GN_LO:
    assert property (p_upd(6'h17, {cal_o.chan2_gain[7:0], 8'h00}, 16'hff00)) else $error("gain low lost");
  AST_DC_EN:
    assert property ($past(rst_b_i) && $past(ce_i) |-> cal_o.chan2_dc_removal_en ==
      ($past(global_dc_removal_setting_i) && !cal_o.chan2_dc_removal_off)) else $error("dc enable wrong");
  AST_SEL:
    assert property (cal_o.chan2_input_onehot == 4'h1 << cal_o.chan2_input_select) else $error("select wrong");
  AST_RST:
    assert property ($rose(rst_b_i) |-> cal_o.chan2_gain == 24'h800000 && cal_o.chan2_offset == 24'h0
      && cal_o.chan2_delay_field == 10'h0 && cal_o.chan2_input_select == 2'h0) else $error("reset value wrong");
  AST_CFG_RSV:
    assert property (rd_ack && ix == 6'h13 |-> avs_readdata_o[5:3] == 3'h0) else $error("cfg reserved set");
  AST_LO_RSV:
    assert property (rd_ack && ix inside {6'h12, 6'h15, 6'h17} |-> avs_readdata_o[7:0] == 8'h00)
      else $error("low reserved set");
endmodule // ccr_regs_chk

bind ccr_regs ccr_regs_chk u_chk (.clock_i, .rst_b_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .global_dc_removal_setting_i, .cal_o);

// ---- bench/test_ccr_regs.sv ----
`timescale 1ns/1ps
module test_ccr_regs
  import ccr_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic glob = 1'b0;
  logic [31:0] rdata;
  logic [1:0] resp;
  logic wreq;
  ccr_cal_s cal;
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic [1:0] r;
  always #5 clock_i = ~clock_i;
  ccr_regs DUT (.clock_i, .rst_b_i, .ce_i, .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_response_o(resp),
    .avs_waitrequest_o(wreq), .global_dc_removal_setting_i(glob), .cal_o(cal));
  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the leading edge keeps a release and the next request out of one time step
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    int n;
    n = 0;
    @(posedge clock_i);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {16'h0, d};
    be <= {2'h0, b};
    @(posedge clock_i);
    while (wreq !== 1'b0) begin
      n++;
      if (n > 20) begin
        mismatches++;
        summarize();
      end
      @(posedge clock_i);
    end
    q = rdata;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    bus(1'b0, a, 16'h0, 2'h3);
    cmp(q, {16'h0, e});
    cmp({30'h0, r}, {30'h0, er});
  endtask
  initial begin
    for (int k = 0; k < 2; k++) begin
      rst_b_i <= 1'b0;
      repeat (20) @(posedge clock_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 6; i++) begin
        rchk(8'h48 + 8'(4 * i), CCR_RESET[i], CCR_RESP_OKAY);
        bus(1'b1, 8'h48 + 8'(4 * i), 16'hffff, 2'h3);
        rchk(8'h48 + 8'(4 * i), CCR_WMASK[i], CCR_RESP_OKAY);
        bus(1'b1, 8'h48 + 8'(4 * i), 16'h5a3c, 2'h3);
      end
      repeat (2) @(posedge clock_i);
      cmp(32'(cal.chan2_offset), 32'h5a3c5a);
      cmp(32'(cal.chan2_gain), 32'h5a3c5a);
      cmp(32'(cal.chan1_gain_low), 32'h5a);
      cmp(32'(cal.chan2_delay_field), 32'h168);
      bus(1'b1, 8'h50, 16'h0000, 2'h1);
      rchk(8'h50, 16'h5a00, CCR_RESP_OKAY);
      bus(1'b1, 8'h50, 16'ha5ff, 2'h2);
      rchk(8'h50, 16'ha500, CCR_RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
        glob <= i[1];
        bus(1'b1, 8'h4c, 16'(i), 2'h3);
        repeat (2) @(posedge clock_i);
        cmp(32'(cal.chan2_input_onehot), 32'h1 << i[1:0]);
        cmp(32'(cal.chan2_dc_removal_en), 32'(i[1] && !i[2]));
      end
      // ce low must freeze the registered view while its input moves
      bus(1'b1, 8'h4c, 16'h0000, 2'h3);
      glob <= 1'b1;
      repeat (3) @(posedge clock_i);
      ce_i <= 1'b0;
      glob <= 1'b0;
      repeat (3) @(posedge clock_i);
      cmp(32'(cal.chan2_dc_removal_en), 32'h1);
      ce_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      cmp(32'(cal.chan2_dc_removal_en), 32'h0);
      // unmapped places answer with an error and hold nothing
      bus(1'b1, 8'h60, 16'hffff, 2'h3);
      cmp({30'h0, r}, {30'h0, CCR_RESP_SLVERR});
      rchk(8'h60, 16'h0000, CCR_RESP_SLVERR);
      rchk(8'h44, 16'h0000, CCR_RESP_SLVERR);
    end
    summarize();
  end
endmodule // test_ccr_regs
